// *** design/cshp_top.sv ***
module cshp_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic trig_src_external,
  input wire logic list_sweep_mode,
  input wire logic remote_measure_trigger,
  input wire logic internal_trigger,
  input wire logic analog_done,
  input wire logic [cshp_pkg::VAL_W-1:0] primary_value,
  input wire logic [cshp_pkg::VAL_W-1:0] secondary_value,
  input wire logic [cshp_pkg::NUM_BINS*cshp_pkg::VAL_W-1:0] bin_upper,
  input wire logic [cshp_pkg::NUM_BINS*cshp_pkg::VAL_W-1:0] bin_lower,
  input wire logic [cshp_pkg::VAL_W-1:0] sec_upper,
  input wire logic [cshp_pkg::VAL_W-1:0] sec_lower,
  input wire logic aux_enable,
  input wire logic [cshp_pkg::NUM_BINS:0] sweep_out_of_limit,
  input wire logic sweep_any_fail,
  input wire logic circuit_open,
  input wire logic panel_lockout_n,
  input wire logic [7:0] panel_keys,
  output logic [7:0] panel_keys_gated,
  output logic measure_start,
  output logic [cshp_pkg::NUM_BINS-1:0] sort_bin_lines_n,
  output logic reject_line_n,
  output logic aux_bin_line_n,
  output logic primary_high_flag_n,
  output logic primary_low_flag_n,
  output logic secondary_reject_flag_n,
  output logic analog_done_strobe_n,
  output logic measurement_end_strobe_n,
  output logic contact_alarm_n
);

  // ****************************************
  // Trigger edge detect
  // ****************************************
  logic trig_prev_ff;
  logic nxt_trig_prev;
  logic start_req;

  always_comb begin
    nxt_trig_prev = remote_measure_trigger;
    start_req = trig_src_external ? (remote_measure_trigger & ~trig_prev_ff) // see RULE1
                                  : internal_trigger;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trig_prev_ff <= 1'b0;
    end else begin
      trig_prev_ff <= nxt_trig_prev;
    end
  end

  // ****************************************
  // Comparison
  // ****************************************
  function automatic logic [cshp_pkg::VAL_W-1:0] lim(
    input logic [cshp_pkg::NUM_BINS*cshp_pkg::VAL_W-1:0] v, input int i);
    lim = v[i*cshp_pkg::VAL_W +: cshp_pkg::VAL_W];
  endfunction

  logic [cshp_pkg::NUM_BINS-1:0] cmp_bins;
  logic cmp_rej, cmp_phi, cmp_plo, cmp_secondary_reject_flag, cmp_aux;
  logic found;

  always_comb begin
    cmp_bins = cshp_pkg::BINS_IDLE;
    found = 1'b0;
    for (int i = 0; i < cshp_pkg::NUM_BINS; i++) begin
      if (!found && primary_value >= lim(bin_lower, i) && primary_value <= lim(bin_upper, i)) begin
        cmp_bins[i] = 1'b1; // see RULE14
        found = 1'b1;
      end
    end
    cmp_phi = primary_value > lim(bin_upper, cshp_pkg::NUM_BINS - 1); // see RULE4
    cmp_plo = primary_value < lim(bin_lower, 0); // see RULE5
    cmp_secondary_reject_flag = (secondary_value > sec_upper) || (secondary_value < sec_lower); // see RULE6
    cmp_rej = !found;
    cmp_aux = 1'b0;
    if (found && cmp_secondary_reject_flag && aux_enable) begin
      cmp_bins = cshp_pkg::BINS_IDLE;
      cmp_aux = 1'b1;
    end else if (found && cmp_secondary_reject_flag) begin
      cmp_bins = cshp_pkg::BINS_IDLE;
      cmp_rej = 1'b1;
    end
    if (list_sweep_mode) begin
      cmp_bins = sweep_out_of_limit[cshp_pkg::NUM_BINS-1:0]; // see RULE13
      cmp_rej = sweep_out_of_limit[cshp_pkg::NUM_BINS];
      cmp_aux = sweep_any_fail;
      cmp_phi = 1'b0;
      cmp_plo = 1'b0;
      cmp_secondary_reject_flag = 1'b0;
    end
  end

  // ****************************************
  // Sequencer and output registers
  // ****************************************
  cshp_pkg::cshp_state_type state_ff, nxt_state;
  logic [3:0] idx_cnt_ff, nxt_idx_cnt;
  logic [3:0] eom_cnt_ff, nxt_eom_cnt;
  logic [cshp_pkg::NUM_BINS-1:0] bins_ff, nxt_bins;
  logic rej_ff, nxt_rej, aux_ff, nxt_aux;
  logic phi_ff, nxt_phi, plo_ff, nxt_plo, secondary_reject_flag_ff, nxt_secondary_reject_flag;
  logic idx_ff, nxt_idx, eom_ff, nxt_eom, alarm_ff, nxt_alarm, start_ff, nxt_start;
  logic [7:0] keys_ff, nxt_keys;

  always_comb begin
    nxt_state = state_ff;
    nxt_idx_cnt = idx_cnt_ff;
    nxt_eom_cnt = eom_cnt_ff;
    nxt_bins = bins_ff;
    nxt_rej = rej_ff;
    nxt_aux = aux_ff;
    nxt_phi = phi_ff;
    nxt_plo = plo_ff;
    nxt_secondary_reject_flag = secondary_reject_flag_ff;
    nxt_idx = 1'b0;
    nxt_eom = 1'b0;
    nxt_start = 1'b0;
    nxt_alarm = circuit_open; // see RULE11
    nxt_keys = panel_lockout_n ? panel_keys : 8'h00; // see RULE12
    if (idx_cnt_ff != 4'h0) begin
      nxt_idx = 1'b1;
      nxt_idx_cnt = idx_cnt_ff - 4'h1;
    end
    if (eom_cnt_ff != 4'h0) begin
      nxt_eom = 1'b1;
      nxt_eom_cnt = eom_cnt_ff - 4'h1;
    end
    case (state_ff)
      cshp_pkg::CSHP_IDLE: begin
        if (start_req) begin
          nxt_start = 1'b1;
          nxt_state = cshp_pkg::CSHP_ANALOG;
        end
      end
      cshp_pkg::CSHP_ANALOG: begin
        if (analog_done) begin
          nxt_idx = 1'b1; // see RULE8
          nxt_idx_cnt = cshp_pkg::STROBE_LAST;
          nxt_state = cshp_pkg::CSHP_COMPARE;
        end
      end
      cshp_pkg::CSHP_COMPARE: begin
        // Results latched and held until next compare
        nxt_bins = cmp_bins; // see RULE7
        nxt_rej = cmp_rej;
        nxt_aux = cmp_aux;
        nxt_phi = cmp_phi;
        nxt_plo = cmp_plo;
        nxt_secondary_reject_flag = cmp_secondary_reject_flag;
        nxt_state = cshp_pkg::CSHP_DONE;
      end
      cshp_pkg::CSHP_DONE: begin
        // End strobe one cycle after outputs settle
        nxt_eom = 1'b1; // see RULE9 RULE10
        nxt_eom_cnt = cshp_pkg::STROBE_LAST;
        nxt_state = cshp_pkg::CSHP_IDLE;
      end
      default: nxt_state = cshp_pkg::CSHP_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= cshp_pkg::CSHP_IDLE;
      idx_cnt_ff <= 4'h0;
      eom_cnt_ff <= 4'h0;
      bins_ff <= cshp_pkg::BINS_IDLE;
      rej_ff <= 1'b0;
      aux_ff <= 1'b0;
      phi_ff <= 1'b0;
      plo_ff <= 1'b0;
      secondary_reject_flag_ff <= 1'b0;
      idx_ff <= 1'b0;
      eom_ff <= 1'b0;
      alarm_ff <= 1'b0;
      start_ff <= 1'b0;
      keys_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      idx_cnt_ff <= nxt_idx_cnt;
      eom_cnt_ff <= nxt_eom_cnt;
      bins_ff <= nxt_bins;
      rej_ff <= nxt_rej;
      aux_ff <= nxt_aux;
      phi_ff <= nxt_phi;
      plo_ff <= nxt_plo;
      secondary_reject_flag_ff <= nxt_secondary_reject_flag;
      idx_ff <= nxt_idx;
      eom_ff <= nxt_eom;
      alarm_ff <= nxt_alarm;
      start_ff <= nxt_start;
      keys_ff <= nxt_keys;
    end
  end

  // ****************************************
  // Active-low pins, plus active-high measure_start and panel_keys_gated
  // ****************************************
  always_comb begin
    sort_bin_lines_n = ~bins_ff; // see RULE3
    reject_line_n = ~rej_ff;
    aux_bin_line_n = ~aux_ff;
    primary_high_flag_n = ~phi_ff;
    primary_low_flag_n = ~plo_ff;
    secondary_reject_flag_n = ~secondary_reject_flag_ff;
    analog_done_strobe_n = ~idx_ff;
    measurement_end_strobe_n = ~eom_ff;
    contact_alarm_n = ~alarm_ff;
    measure_start = start_ff;
    panel_keys_gated = keys_ff;
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_trig_start;
    @(posedge clk) disable iff (rst)
      (trig_src_external && remote_measure_trigger && !trig_prev_ff
       && state_ff == cshp_pkg::CSHP_IDLE) |=> measure_start;
  endproperty
  a_trig_start: assert property (p_trig_start) else $error("edge did not start"); // see RULE1

  property p_onehot;
    @(posedge clk) disable iff (rst)
      (state_ff == cshp_pkg::CSHP_COMPARE && !list_sweep_mode)
        |=> $onehot0({~sort_bin_lines_n, ~reject_line_n});
  endproperty
  a_onehot: assert property (p_onehot) else $error("several bins asserted"); // see RULE14

  property p_phi;
    @(posedge clk) disable iff (rst)
      (state_ff == cshp_pkg::CSHP_COMPARE && !list_sweep_mode)
        |=> primary_high_flag_n
            == !$past(primary_value > lim(bin_upper, cshp_pkg::NUM_BINS - 1));
  endproperty
  a_phi: assert property (p_phi) else $error("high flag missing"); // see RULE4

  property p_plo;
    @(posedge clk) disable iff (rst)
      (state_ff == cshp_pkg::CSHP_COMPARE && !list_sweep_mode)
        |=> primary_low_flag_n
            == !$past(primary_value < lim(bin_lower, 0));
  endproperty
  a_plo: assert property (p_plo) else $error("low flag missing"); // see RULE5

  property p_secondary_reject_flag;
    @(posedge clk) disable iff (rst)
      (state_ff == cshp_pkg::CSHP_COMPARE && !list_sweep_mode)
        |=> secondary_reject_flag_n
            == !$past(secondary_value > sec_upper || secondary_value < sec_lower);
  endproperty
  a_secondary_reject_flag: assert property (p_secondary_reject_flag) else $error("secondary reject missing"); // see RULE6

  property p_index;
    @(posedge clk) disable iff (rst)
      (state_ff == cshp_pkg::CSHP_ANALOG && analog_done) |=> !analog_done_strobe_n [*4];
  endproperty
  a_index: assert property (p_index) else $error("analog strobe wrong"); // see RULE8

  property p_eom_stable;
    @(posedge clk) disable iff (rst)
      $fell(measurement_end_strobe_n) |-> $stable(sort_bin_lines_n) && $stable(reject_line_n);
  endproperty
  a_eom_stable: assert property (p_eom_stable) else $error("outputs moved at end"); // see RULE10

  property p_alarm;
    @(posedge clk) disable iff (rst) circuit_open |=> !contact_alarm_n;
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm missing"); // see RULE11

  property p_lock;
    @(posedge clk) disable iff (rst) !panel_lockout_n |=> panel_keys_gated == 8'h00;
  endproperty
  a_lock: assert property (p_lock) else $error("key passed under lock"); // see RULE12

  property p_sweep;
    @(posedge clk) disable iff (rst)
      (state_ff == cshp_pkg::CSHP_COMPARE && list_sweep_mode)
        |=> ~sort_bin_lines_n == $past(sweep_out_of_limit[cshp_pkg::NUM_BINS-1:0]);
  endproperty
  a_sweep: assert property (p_sweep) else $error("sweep bins wrong"); // see RULE13

  property p_hold;
    @(posedge clk) disable iff (rst)
      state_ff != cshp_pkg::CSHP_COMPARE
        |=> $stable(sort_bin_lines_n) && $stable(reject_line_n) && $stable(aux_bin_line_n);
  endproperty
  a_hold: assert property (p_hold) else $error("bin result moved"); // see RULE14

  property p_flag_hold;
    @(posedge clk) disable iff (rst)
      state_ff != cshp_pkg::CSHP_COMPARE
        |=> $stable(primary_high_flag_n) && $stable(primary_low_flag_n)
            && $stable(secondary_reject_flag_n);
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag result moved"); // see RULE9

  c_ext: cover property (@(posedge clk) disable iff (rst) trig_src_external && measure_start);
  c_eom: cover property (@(posedge clk) disable iff (rst) $fell(measurement_end_strobe_n));
  c_aux: cover property (@(posedge clk) disable iff (rst) !aux_bin_line_n);
  c_sweep: cover property (@(posedge clk) disable iff (rst) list_sweep_mode && !reject_line_n);
  c_plo: cover property (@(posedge clk) disable iff (rst) !primary_low_flag_n);

endmodule

// *** design/cshp_pkg.sv ***
// Functional notes
// RULE1 - In external trigger mode each rising edge of the remote trigger input starts a measurement; the code only acts on an edge in CSHP_IDLE.
// RULE2 - The handler holds each trigger pulse for at least one microsecond.
// RULE3 - Every handler output is active low, low meaning asserted; the code drives measure_start and panel_keys_gated active high.
// RULE4 - In bin mode the primary high flag is asserted when the primary value exceeds the bin upper limit.
// RULE5 - In bin mode the primary low flag is asserted when the primary value is below the bin lower limit.
// RULE6 - The secondary reject flag is asserted when the secondary value lies outside its window.
// RULE7 - The result is driven on nine bin lines, one reject line and one auxiliary line.
// RULE8 - The analog-done strobe is asserted when the analog part of a test has finished.
// RULE9 - Comparison outputs are only valid from the measurement-end strobe onward.
// RULE10 - The measurement-end strobe is asserted only when data and comparison are valid on the outputs.
// RULE11 - The contact fault alarm is asserted while the measurement circuit is interrupted.
// RULE12 - While the panel lockout input is asserted all front-panel key presses are ignored.
// RULE13 - In list sweep mode the comparison lines carry their list-sweep meaning instead.
// RULE14 - In bin mode at most one bin or reject line is asserted and held until the next result.
package cshp_pkg;
  localparam int unsigned NUM_BINS = 9;
  localparam int unsigned VAL_W = 24;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned TRIG_MIN_NS = 1000;
  localparam int unsigned CLK_NS = 1_000_000_000 / CLK_HZ;
  localparam int unsigned TRIG_MIN_CYC = (TRIG_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned STROBE_CYC = 4;
  localparam logic [3:0] STROBE_LAST = 4'(STROBE_CYC - 1);
  localparam logic [NUM_BINS-1:0] BINS_IDLE = {NUM_BINS{1'b0}};
  typedef enum logic [1:0] {
    CSHP_IDLE,
    CSHP_ANALOG,
    CSHP_COMPARE,
    CSHP_DONE
  } cshp_state_type;
endpackage

// *** sim/cshp_handler_model.sv ***
module cshp_handler_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic go,
  input wire logic eom_n,
  input wire logic [13:0] res_n,
  output logic trig,
  output logic busy,
  output logic [13:0] seen
);
  timeunit 1ns;
  timeprecision 1ns;
  logic eom_q = 1'b1;
  // ****************************************
  // Trigger pulse, held the minimum width
  // ****************************************
  initial begin
    trig = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge clk iff go);
      busy = 1'b1;
      @(negedge clk) trig = 1'b1;
      repeat (cshp_pkg::TRIG_MIN_CYC) @(negedge clk);
      trig = 1'b0;
      @(negedge clk) busy = 1'b0;
    end
  end
  // ****************************************
  // Result sampled only at end strobe
  // ****************************************
  always @(posedge clk) begin
    if (!rst && !eom_n && eom_q) seen <= res_n;
    eom_q <= eom_n;
  end
endmodule

// *** sim/component_sorting_handler_port_test.sv ***
module component_sorting_handler_port_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int W = cshp_pkg::VAL_W;
  localparam int NB = cshp_pkg::NUM_BINS;
  logic clk = 0, rst = 1, trig_src_external = 1, list_sweep_mode = 0, go = 0, busy;
  logic remote_measure_trigger, internal_trigger = 0, analog_done = 0, aux_enable = 0;
  logic [W-1:0] primary_value = '0, secondary_value = '0;
  logic [W-1:0] sec_upper = 24'hc8, sec_lower = 24'h64;
  logic [NB*W-1:0] bin_upper, bin_lower;
  logic sweep_any_fail = 0, circuit_open = 0, panel_lockout_n = 1;
  logic [NB:0] sweep_out_of_limit = '0;
  logic [7:0] panel_keys = '0, panel_keys_gated;
  logic measure_start, reject_line_n, aux_bin_line_n, primary_high_flag_n;
  logic primary_low_flag_n, secondary_reject_flag_n, analog_done_strobe_n;
  logic measurement_end_strobe_n, contact_alarm_n;
  logic [NB-1:0] sort_bin_lines_n;
  logic [13:0] seen, res_n;
  int miscompares = 0, total_checks = 0;
  assign res_n = {sort_bin_lines_n, reject_line_n, aux_bin_line_n, primary_high_flag_n,
                  primary_low_flag_n, secondary_reject_flag_n};
  always #10 clk = ~clk;
  cshp_top u_dut (.clk, .rst, .trig_src_external, .list_sweep_mode, .remote_measure_trigger,
    .internal_trigger, .analog_done, .primary_value, .secondary_value, .bin_upper, .bin_lower,
    .sec_upper, .sec_lower, .aux_enable, .sweep_out_of_limit, .sweep_any_fail, .circuit_open,
    .panel_lockout_n, .panel_keys, .panel_keys_gated, .measure_start, .sort_bin_lines_n,
    .reject_line_n, .aux_bin_line_n, .primary_high_flag_n, .primary_low_flag_n,
    .secondary_reject_flag_n, .analog_done_strobe_n, .measurement_end_strobe_n,
    .contact_alarm_n);
  cshp_handler_model u_hdl (.clk, .rst, .go, .eom_n(measurement_end_strobe_n), .res_n,
    .trig(remote_measure_trigger), .busy, .seen);
  // ****************************************
  // Checking helpers
  // ****************************************
  task automatic chk(input logic [13:0] got, input logic [13:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    if (miscompares == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Bins i span [i*100+10, i*100+90], secondary window [100, 200]
  function automatic logic [13:0] expect_res(input int p, input int s);
    logic [13:0] a;
    int b;
    a = '0;
    b = -1;
    if (list_sweep_mode) return ~{sweep_out_of_limit[8:0], sweep_out_of_limit[9],
                                  sweep_any_fail, 3'h0};
    for (int i = NB - 1; i >= 0; i--) if (p >= i * 100 + 10 && p <= i * 100 + 90) b = i;
    a[2] = p > 890;
    a[1] = p < 10;
    a[0] = s > 200 || s < 100;
    if (b < 0) a[4] = 1'b1;
    else if (a[0]) a[aux_enable ? 3 : 4] = 1'b1;
    else a[5 + b] = 1'b1;
    return ~a;
  endfunction
  task automatic meas(input int p, input int s);
    int n;
    logic [13:0] e;
    @(negedge clk);
    primary_value = W'(p);
    secondary_value = W'(s);
    if (trig_src_external) go = 1'b1;
    else internal_trigger = 1'b1;
    e = expect_res(p, s);
    @(negedge clk);
    go = 1'b0;
    internal_trigger = 1'b0;
    for (n = 0; measure_start !== 1'b1 && n < 100; n++) @(negedge clk);
    chk({13'h0, measure_start}, 14'h1);
    analog_done = 1'b1;
    @(negedge clk);
    analog_done = 1'b0;
    for (n = 0; measurement_end_strobe_n !== 1'b0 && n < 20; n++) @(negedge clk);
    chk({13'h0, analog_done_strobe_n}, 14'h0);
    chk(res_n, e);
    @(negedge clk);
    chk(seen, e);
    for (n = 0; (busy || measurement_end_strobe_n !== 1'b1) && n < 100; n++) @(negedge clk);
    chk({12'h0, busy, measurement_end_strobe_n}, 14'h1);
    chk(res_n, e);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    int n;
    logic [13:0] e;
    void'($urandom(32'h7e16d4db));
    for (int i = 0; i < NB; i++) begin
      bin_lower[i*W+:W] = W'(i * 100 + 10);
      bin_upper[i*W+:W] = W'(i * 100 + 90);
    end
    repeat (3) @(negedge clk);
    chk(res_n, 14'h3fff);
    chk({11'h0, analog_done_strobe_n, measurement_end_strobe_n, contact_alarm_n}, 14'h7);
    rst = 1'b0;
    for (int i = 0; i < 6; i++) meas(i * 178 + 9 + (i == 5), 150);
    meas(150, 99);
    meas(95, 300);
    aux_enable = 1'b1;
    meas(150, 201);
    repeat (12) begin
      aux_enable = 1'($urandom);
      meas($urandom_range(0, 1000), $urandom_range(50, 250));
    end
    trig_src_external = 1'b0;
    repeat (3) meas($urandom_range(0, 1000), 150);
    trig_src_external = 1'b1;
    @(negedge clk) internal_trigger = 1'b1;
    @(negedge clk) internal_trigger = 1'b0;
    n = 0;
    repeat (4) @(negedge clk) n += int'(measure_start);
    chk(14'(n), 14'h0);
    list_sweep_mode = 1'b1;
    repeat (4) begin
      sweep_out_of_limit = 10'($urandom);
      sweep_any_fail = 1'($urandom);
      meas($urandom_range(0, 1000), 150);
    end
    list_sweep_mode = 1'b0;
    repeat (20) begin
      @(negedge clk);
      circuit_open = 1'($urandom);
      panel_lockout_n = 1'($urandom);
      panel_keys = 8'($urandom);
      e = {5'h0, ~circuit_open, panel_lockout_n ? panel_keys : 8'h0};
      @(negedge clk);
      chk({5'h0, contact_alarm_n, panel_keys_gated}, e);
    end
    end_of_test;
  end
  initial begin
    #800000;
    miscompares++;
    end_of_test;
  end
endmodule
